// >>> rtl/opmode_pkg.sv
// Purpose: Constants for the operation mode power sequencer.
// Assumes: Delays are counted in low-speed oscillator cycles.
// Notes: Notes on behaviour follow.
package opmode_pkg;

	localparam int CNT_W = 16;
	localparam int RX_CHANNELS = 5;

	// ----------------------------------------------------------------
	// Power-up schedule in low-speed cycles
	// ----------------------------------------------------------------
	localparam logic [15:0] REF_DELAY = 16'h0000;
	localparam logic [15:0] FAST_OSC_DELAY = 16'h0002;
	localparam logic [15:0] PROC_CLK_DELAY_RST = 16'h001E;
	localparam logic [15:0] PROC_CLK_DELAY_DS = 16'h0008;
	localparam logic [15:0] PWRT_RST = 16'h0024;
	localparam logic [15:0] PWRT_DS = 16'h000A;

	// ----------------------------------------------------------------
	// Self wake-up timing defaults
	// ----------------------------------------------------------------
	localparam logic [15:0] SCAN_TICKS_DEF = 16'h0004;
	localparam logic [15:0] INACT_TICKS_DEF = 16'h0400;

	typedef enum logic [2:0] {
		ST_HELD = 3'b000,
		ST_POWER_UP = 3'b001,
		ST_PROCESSING = 3'b010,
		ST_WAKE_SLEEP = 3'b011,
		ST_WAKE_SCAN = 3'b100,
		ST_POWER_DOWN = 3'b101,
		ST_DEEP_SLEEP = 3'b110
	} seq_state_e;

endpackage : opmode_pkg

// >>> rtl/sync_2ff.sv
// Purpose: Two flip-flop synchroniser for a group of level inputs.
// Assumes: Inputs are asynchronous to core_clk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					meta[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : sync_2ff

// >>> rtl/opmode_sequencer.sv
// Purpose: Operation mode and power-up/down sequencer.
// Assumes: Low-speed oscillator arrives as a pin and is sampled here.
// Notes: All outputs are registered and lag the state by one clock.
`timescale 1ns/1ps
module opmode_sequencer
	import opmode_pkg::*;
#(
	parameter logic [15:0] SCAN_TICKS = SCAN_TICKS_DEF,
	parameter logic [15:0] INACT_TICKS = INACT_TICKS_DEF
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic low_speed_oscillator,
	input wire logic host_wake_line,
	input wire logic i2c_start_detect,
	input wire logic sleep_cmd,
	input wire logic deep_sleep_cmd,
	input wire logic user_present,
	input wire logic approach_detected,
	input wire logic [15:0] wake_period,
	input wire logic [2:0] scan_channels,
	output logic reference_enable,
	output logic fast_oscillator_enable,
	output logic processor_clock,
	output logic analog_regulator_enable,
	output logic watchdog_enable,
	output logic [RX_CHANNELS-1:0] rx_channel_enable,
	output logic approach_enable,
	output logic position_enable,
	output logic gesture_enable,
	output logic [2:0] mode
);
	// ----------------------------------------------------------------
	// Pin synchronisation and low-speed tick
	// ----------------------------------------------------------------
	logic [2:0] pins_sync;
	logic lso_prev;
	sync_2ff #(.WIDTH(3)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.async_in({low_speed_oscillator, host_wake_line, i2c_start_detect}),
		.sync_out(pins_sync)
	);
	wire lso_s = pins_sync[2];
	wire wake_s = pins_sync[1];
	wire start_s = pins_sync[0];
	wire lso_tick = lso_s & ~lso_prev;
	wire host_trigger = wake_s | start_s;

	// ----------------------------------------------------------------
	// State, schedule and counters
	// ----------------------------------------------------------------
	seq_state_e state;
	seq_state_e next_state;
	logic from_deep;
	logic next_from_deep;
	logic [15:0] cnt;
	logic [15:0] inact;

	wire [15:0] proc_delay = from_deep ? PROC_CLK_DELAY_DS : PROC_CLK_DELAY_RST;
	wire [15:0] pwrt = from_deep ? PWRT_DS : PWRT_RST;
	wire state_change = (next_state != state);
	wire [15:0] cnt_inc = cnt + 16'h0001;
	wire [15:0] wake_lim = (wake_period == 16'h0000) ? 16'h0001 : wake_period;
	wire inact_expired = (inact >= INACT_TICKS);

	always_comb begin
		next_state = state;
		next_from_deep = from_deep;
		case (state)
			ST_HELD: begin
				next_state = ST_POWER_UP;
				next_from_deep = 1'b0;
			end
			ST_POWER_UP: begin
				if (lso_tick && cnt_inc >= pwrt) begin
					next_state = ST_PROCESSING;
				end
			end
			ST_PROCESSING: begin
				if (deep_sleep_cmd) begin
					next_state = ST_POWER_DOWN;
				end else if (sleep_cmd || inact_expired) begin
					next_state = ST_WAKE_SLEEP;
				end
			end
			ST_WAKE_SLEEP: begin
				if (host_trigger) begin
					next_state = ST_PROCESSING;
				end else if (lso_tick && cnt_inc >= wake_lim) begin
					next_state = ST_WAKE_SCAN;
				end
			end
			ST_WAKE_SCAN: begin
				if (host_trigger || approach_detected) begin
					next_state = ST_PROCESSING;
				end else if (lso_tick && cnt_inc >= SCAN_TICKS) begin
					next_state = ST_WAKE_SLEEP;
				end
			end
			ST_POWER_DOWN: begin
				if (lso_tick) begin
					next_state = ST_DEEP_SLEEP;
				end
			end
			// Only a host trigger ends deep sleep
			ST_DEEP_SLEEP: begin
				if (host_trigger) begin
					next_state = ST_POWER_UP;
					next_from_deep = 1'b1;
				end
			end
			default: begin
				next_state = ST_HELD;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_HELD;
			from_deep <= 1'b0;
			lso_prev <= 1'b0;
		end else begin
			state <= next_state;
			from_deep <= next_from_deep;
			lso_prev <= lso_s;
		end
	end

	// Counter restarts on every state change so each phase times itself
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 16'h0000;
		end else if (state_change) begin
			cnt <= 16'h0000;
		end else if (lso_tick) begin
			cnt <= cnt_inc;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			inact <= 16'h0000;
		end else if (state != ST_PROCESSING || user_present) begin
			inact <= 16'h0000;
		end else if (lso_tick && !inact_expired) begin
			inact <= inact + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Output decode
	// ----------------------------------------------------------------
	wire in_pu = (state == ST_POWER_UP);
	wire in_proc = (state == ST_PROCESSING);
	wire in_scan = (state == ST_WAKE_SCAN);
	wire in_wake = in_scan || (state == ST_WAKE_SLEEP);
	wire analog_on = in_proc || in_wake;
	wire next_ref = analog_on || (in_pu && cnt >= REF_DELAY);
	wire next_fast = in_proc || in_scan || (in_pu && cnt >= FAST_OSC_DELAY);
	wire next_pclk = in_proc || in_scan || (in_pu && cnt >= proc_delay);
	// Regulator and watchdog off in deep sleep
	wire deep_side = (state == ST_DEEP_SLEEP) || (state == ST_POWER_DOWN);
	wire next_reg = !deep_side && (state != ST_HELD);
	wire next_wdog = !deep_side;
	logic [RX_CHANNELS-1:0] next_rx;
	genvar c;
	generate
		for (c = 0; c < RX_CHANNELS; c++) begin : g_rx
			assign next_rx[c] = in_proc || (in_scan && (3'(c) < scan_channels));
		end
	endgenerate

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reference_enable <= 1'b0;
			fast_oscillator_enable <= 1'b0;
			processor_clock <= 1'b0;
			analog_regulator_enable <= 1'b0;
			watchdog_enable <= 1'b0;
			rx_channel_enable <= '0;
			approach_enable <= 1'b0;
			position_enable <= 1'b0;
			gesture_enable <= 1'b0;
			mode <= 3'h0;
		end else begin
			reference_enable <= next_ref;
			fast_oscillator_enable <= next_fast;
			processor_clock <= next_pclk;
			analog_regulator_enable <= next_reg;
			watchdog_enable <= next_wdog;
			rx_channel_enable <= next_rx;
			approach_enable <= in_scan;
			position_enable <= in_proc;
			gesture_enable <= in_proc;
			mode <= state;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Results only in processing
	a_results_proc_only: assert property (
		@(posedge core_clk) disable iff (!nrst)
		position_enable |-> $past(state) == ST_PROCESSING)
		else $error("position output outside processing");
	a_proc_all_rx: assert property (
		@(posedge core_clk) disable iff (!nrst)
		in_proc |=> rx_channel_enable == 5'h1F)
		else $error("processing without all channels");
	a_scan_subset: assert property (
		@(posedge core_clk) disable iff (!nrst)
		in_scan && scan_channels == 3'h1 |=> rx_channel_enable == 5'h01
		&& approach_enable)
		else $error("scan channel subset wrong");
	a_deep_off: assert property (
		@(posedge core_clk) disable iff (!nrst)
		state == ST_DEEP_SLEEP |=> !processor_clock && !watchdog_enable
		&& !analog_regulator_enable)
		else $error("deep sleep left something on");
	a_power_down: assert property (
		@(posedge core_clk) disable iff (!nrst)
		in_proc && deep_sleep_cmd |=> state == ST_POWER_DOWN
		##1 !reference_enable && !fast_oscillator_enable)
		else $error("power-down state skipped");
	a_fast_osc: assert property (
		@(posedge core_clk) disable iff (!nrst)
		in_pu && cnt < FAST_OSC_DELAY |=> !fast_oscillator_enable
		&& reference_enable)
		else $error("fast oscillator enabled early");
	a_pclk_delay: assert property (
		@(posedge core_clk) disable iff (!nrst)
		in_pu && cnt < proc_delay |=> !processor_clock)
		else $error("processor clock started early");
	a_pwrt_end: assert property (
		@(posedge core_clk) disable iff (!nrst)
		in_pu && next_state == ST_PROCESSING |->
		cnt == (from_deep ? 16'h0009 : 16'h0023))
		else $error("power-up timeout wrong length");
	// Deep schedule only after deep sleep
	a_sched_sel: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$rose(from_deep) |-> $past(state) == ST_DEEP_SLEEP)
		else $error("deep schedule without deep sleep");
	a_held_first: assert property (
		@(posedge core_clk) disable iff (!nrst)
		state == ST_HELD |=> state == ST_POWER_UP && !from_deep)
		else $error("power-up did not follow release");
endmodule : opmode_sequencer

// >>> test/host_model.sv
// Purpose: Host side model that wakes the sequencer; slow clock source.
// Assumes: Requests come from the bench on falling core_clk edges.
// Notes: Start indication stands 4 clocks so the 2FF stage catches it.
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk,
	input wire logic wake_req,
	input wire logic start_req,
	output logic host_wake_line,
	output logic i2c_start_detect,
	output logic low_speed_oscillator
);
	logic [2:0] hold = 3'h0;
	logic wake_q = 1'b0;
	initial begin
		low_speed_oscillator = 1'b0;
		forever #40 low_speed_oscillator = ~low_speed_oscillator;
	end
	// Host trigger for wake
	// Plain always: the state starts from its declared value, with no reset
	always @(posedge core_clk) begin
		wake_q <= wake_req;
		hold <= start_req ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
	end
	assign host_wake_line = wake_q;
	assign i2c_start_detect = hold != 3'h0;
endmodule : host_model

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the operation mode sequencer.
// Assumes: One slow tick every 8 core clocks.
// Notes: Delays are checked as tick differences, immune to sync lag.
`timescale 1ns/1ps
module tb_top;
	import opmode_pkg::*;
	logic core_clk, nrst, wake_req, start_req, sleep_cmd, deep_sleep_cmd;
	logic user_present, approach_detected, low_speed_oscillator;
	logic host_wake_line, i2c_start_detect, reference_enable;
	logic fast_oscillator_enable, processor_clock, analog_regulator_enable;
	logic watchdog_enable, approach_enable, position_enable, gesture_enable;
	logic [15:0] wake_period;
	logic [2:0] scan_channels, mode;
	logic [4:0] rx_channel_enable;
	int num_errors, n_tests, ticks, cycles;

	host_model i_host (.core_clk, .wake_req, .start_req, .host_wake_line,
		.i2c_start_detect, .low_speed_oscillator);
	opmode_sequencer #(.INACT_TICKS(16'h0004)) i_dut (.core_clk, .nrst,
		.low_speed_oscillator, .host_wake_line, .i2c_start_detect,
		.sleep_cmd, .deep_sleep_cmd, .user_present, .approach_detected,
		.wake_period, .scan_channels, .reference_enable,
		.fast_oscillator_enable, .processor_clock, .analog_regulator_enable,
		.watchdog_enable, .rx_channel_enable, .approach_enable,
		.position_enable, .gesture_enable, .mode);

	task automatic close_out();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_mode(input logic [2:0] m);
		int k;
		k = 0;
		while (mode !== m && k < 2000) begin
			@(negedge core_clk);
			k++;
		end
		chk(mode, m);
	endtask : wait_mode

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask : pulse

	// Gaps are counted from the fast oscillator enable
	task automatic power_up(input int g_pclk, input int g_end);
		int k, t_fast, t_pclk;
		k = 0;
		t_fast = -1;
		t_pclk = -1;
		wait_mode(3'h1);
		while (mode !== 3'h2 && k < 2000) begin
			@(negedge core_clk);
			k++;
			if (fast_oscillator_enable === 1'b1 && t_fast < 0) begin
				t_fast = ticks;
				chk({reference_enable, processor_clock}, 16'h0002);
			end
			if (processor_clock === 1'b1 && t_pclk < 0)
				t_pclk = ticks;
		end
		chk(mode, 3'h2);
		chk(16'(t_pclk - t_fast), 16'(g_pclk));
		chk(16'(ticks - t_fast), 16'(g_end));
	endtask : power_up

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge low_speed_oscillator) ticks++;

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end

	initial begin
		nrst = 1'b0;
		wake_req = 1'b0;
		start_req = 1'b0;
		sleep_cmd = 1'b0;
		deep_sleep_cmd = 1'b0;
		user_present = 1'b1;
		approach_detected = 1'b0;
		wake_period = 16'h0003;
		scan_channels = 3'h2;
		repeat (8) @(negedge core_clk);
		chk({mode, reference_enable}, 16'h0000);
		nrst = 1'b1;
		power_up(28, 34);
		@(negedge core_clk);
		chk(rx_channel_enable, 16'h001F);
		chk({analog_regulator_enable, watchdog_enable}, 16'h0003);
		chk({position_enable, gesture_enable}, 16'h0003);
		pulse(sleep_cmd);
		wait_mode(3'h3);
		@(negedge core_clk);
		chk({position_enable, gesture_enable}, 16'h0000);
		chk(rx_channel_enable, 16'h0000);
		wait_mode(3'h4);
		chk(rx_channel_enable, 16'h0003);
		chk(approach_enable, 16'h0001);
		approach_detected = 1'b1;
		wait_mode(3'h2);
		approach_detected = 1'b0;
		// Second visit: one channel, scan lapses back to sleep
		pulse(sleep_cmd);
		scan_channels = 3'h1;
		wait_mode(3'h4);
		chk(rx_channel_enable, 16'h0001);
		wait_mode(3'h3);
		wake_req = 1'b1;
		wait_mode(3'h2);
		wake_req = 1'b0;
		user_present = 1'b0;
		wait_mode(3'h3);
		user_present = 1'b1;
		pulse(start_req);
		wait_mode(3'h2);
		pulse(deep_sleep_cmd);
		wait_mode(3'h5);
		@(negedge core_clk);
		chk({reference_enable, fast_oscillator_enable}, 16'h0000);
		wait_mode(3'h6);
		repeat (24) @(negedge core_clk);
		chk({processor_clock, analog_regulator_enable}, 16'h0000);
		chk({watchdog_enable, position_enable}, 16'h0000);
		pulse(sleep_cmd);
		repeat (8) @(negedge core_clk);
		chk(mode, 3'h6);
		wake_req = 1'b1;
		power_up(6, 8);
		wake_req = 1'b0;
		nrst = 1'b0;
		@(negedge core_clk);
		chk({mode, reference_enable, watchdog_enable}, 16'h0000);
		nrst = 1'b1;
		power_up(28, 34);
		close_out();
	end
endmodule : tb_top
